//--- verilog/rctr_map.vh
// Purpose: Constants for the remote command and tolerance relay block
// Assumes: 25 MHz clock
// Notes:   Hold time in ms, cycle count derived from it
`ifndef RCTR_MAP_VH
`define RCTR_MAP_VH
`define RCTR_CLK_HZ        25000000
`define RCTR_HOLD_MS       50
// Least time, rounds up to whole cycles
`define RCTR_HOLD_CYC      ((`RCTR_HOLD_MS * `RCTR_CLK_HZ + 999) / 1000)
`define RCTR_CNT_W         21
`define RCTR_VAL_W         32
// Command input bit positions
`define RCTR_BIT_INIT      0
`define RCTR_BIT_STOP      1
`define RCTR_BIT_ZERO      2
`define RCTR_BIT_PRINT     3
`define RCTR_BIT_PRESET    4
`define RCTR_NCMD          5
`endif

//--- verilog/rctr_top.v
// Purpose: Remote command inputs and tolerance relay outputs
// Assumes: Single 25 MHz clock, synchronous active-low reset
// Notes:   Measurement values arrive already on clk; pins are synchronised
//          Commands act on release after a full hold; stop acts on level
//          Relay outputs are 1 when the contact is closed
//          A pin held through reset starts its count after release
`timescale 1ns/1ps
`default_nettype none
`include "rctr_map.vh"

// Timing, in clk edges with clk_en high:
//   Pin rise to qualified  : 2 sync edges plus HOLD_CYC samples
//   Pin fall to fire       : 2 sync edges
//   Fire to strobe or value: 1 edge
//   Display to relays      : 1 edge
// A low clk_en freezes every register, hold counters included.

module rctr_top #(
    parameter HOLD_CYC = `RCTR_HOLD_CYC
) (
    // Clock, reset, enable
    input  wire                     clk,
    input  wire                     reset_n,
    input  wire                     clk_en,
    // Command pins, active high
    input  wire                     dynamic_memory_init_pin,
    input  wire                     stop_pin,
    input  wire                     zero_pin,
    input  wire                     print_pin,
    input  wire                     preset_pin,
    // Measurement and limits, signed
    input  wire [`RCTR_VAL_W-1:0]   raw_measure,
    input  wire [`RCTR_VAL_W-1:0]   master_value,
    input  wire [`RCTR_VAL_W-1:0]   lower_tol,
    input  wire [`RCTR_VAL_W-1:0]   upper_tol,
    // Display and actions
    output reg  [`RCTR_VAL_W-1:0]   display_value,
    output reg  [`RCTR_VAL_W-1:0]   dyn_max,
    output reg  [`RCTR_VAL_W-1:0]   dyn_min,
    output reg                      measure_frozen,
    output reg                      dynamic_memory_init_cmd,
    output reg                      print_req,
    output reg  [`RCTR_VAL_W-1:0]   print_value,
    // Relay contacts, 1 = contact closed
    output reg                      low_limit_relay_open_contact,
    output reg                      low_limit_relay_closed_contact,
    output reg                      high_limit_relay_open_contact,
    output reg                      high_limit_relay_closed_contact
);

    // Synchroniser stages; the opto pins are asynchronous to clk
    reg  [`RCTR_NCMD-1:0]   sync1_reg;     // First stage, read only by the second
    reg  [`RCTR_NCMD-1:0]   sync2_reg;     // Settled pin levels
    wire [`RCTR_NCMD-1:0]   pin_vec;       // Pins gathered by command bit

    // Hold filter, one counter per command input
    reg  [`RCTR_NCMD-1:0]   qual_reg;      // Held long enough
    reg  [`RCTR_CNT_W-1:0]  cnt_reg [0:`RCTR_NCMD-1];
    wire [`RCTR_NCMD-1:0]   fire;          // Release of a qualified press
    wire                    stopped;       // Stop qualified, updates held
    integer                 i;             // Index of the hold filter loops only

    // Measurement path and tolerance decode
    reg  [`RCTR_VAL_W-1:0]  offset_reg;    // Display origin
    wire [`RCTR_VAL_W-1:0]  shown;         // Live value against the origin
    wire                    low_trip;      // Display below the lower limit
    wire                    high_trip;     // Display above the upper limit

    assign pin_vec = {preset_pin, print_pin, zero_pin, stop_pin, dynamic_memory_init_pin};

    // Signed comparison used by relays and extremes
    // Unsigned compares would trip the high relay on every negative reading against a positive upper limit
    function lt_s;
        input [`RCTR_VAL_W-1:0] a;
        input [`RCTR_VAL_W-1:0] b;
        begin
            lt_s = $signed(a) < $signed(b);
        end
    endfunction

    // Two flops per pin; the first may go metastable, so only the
    // second is read by any logic
    always @(posedge clk) begin
        if (!reset_n) begin
            sync1_reg <= {`RCTR_NCMD{1'b0}};
            sync2_reg <= {`RCTR_NCMD{1'b0}};
        end else if (clk_en) begin
            sync1_reg <= pin_vec;
            sync2_reg <= sync1_reg;
        end
    end

    // Hold counters; a command counts only after the full hold time
    // A low sample restarts the count, so contact chatter never adds up.
    // The count stops at its last value, so a long press cannot wrap it.
    // HOLD_CYC must be at least 1 and below 2**RCTR_CNT_W.
    always @(posedge clk) begin
        if (!reset_n) begin
            qual_reg <= {`RCTR_NCMD{1'b0}};
            for (i = 0; i < `RCTR_NCMD; i = i + 1)
                cnt_reg[i] <= {`RCTR_CNT_W{1'b0}};
        end else if (clk_en) begin
            for (i = 0; i < `RCTR_NCMD; i = i + 1) begin
                if (!sync2_reg[i]) begin
                    cnt_reg[i]  <= {`RCTR_CNT_W{1'b0}};
                    qual_reg[i] <= 1'b0;
                end else if (cnt_reg[i] >= HOLD_CYC[`RCTR_CNT_W-1:0] - 1'b1) begin
                    qual_reg[i] <= 1'b1;
                end else begin
                    cnt_reg[i] <= cnt_reg[i] + 1'b1;
                end
            end
        end
    end

    // Release edge of a qualified press fires the command for one cycle;
    // the qualified flag clears on the very edge that acts on it, so a
    // held pin can never repeat a command
    assign fire = qual_reg & ~sync2_reg;

    // Stop's release fire bit is unused; only its qualified level is used
    assign stopped = qual_reg[`RCTR_BIT_STOP];

    // Live value relative to the chosen origin
    // Wraps modulo 2**RCTR_VAL_W, as the display arithmetic does
    assign shown = raw_measure - offset_reg;

    // Display and origin; zero wins over preset when both release together
    always @(posedge clk) begin
        if (!reset_n) begin
            offset_reg     <= {`RCTR_VAL_W{1'b0}};
            display_value  <= {`RCTR_VAL_W{1'b0}};
            measure_frozen <= 1'b0;
        end else if (clk_en) begin
            // Stop acts on level once qualified, so glitches do not freeze
            measure_frozen <= stopped;
            if (fire[`RCTR_BIT_ZERO]) begin
                // New origin is the live reading, so the display shows 0
                offset_reg    <= raw_measure;
                display_value <= {`RCTR_VAL_W{1'b0}};
            end else if (fire[`RCTR_BIT_PRESET]) begin
                // Origin chosen so the live reading shows the master value
                offset_reg    <= raw_measure - master_value;
                display_value <= master_value;
            end else if (!stopped) begin
                display_value <= shown;
            end
        end
    end

    // Dynamic extremes follow the live value, not the registered display,
    // so they see the same sample the display is about to show
    always @(posedge clk) begin
        if (!reset_n) begin
            dyn_max <= {`RCTR_VAL_W{1'b0}};
            dyn_min <= {`RCTR_VAL_W{1'b0}};
        end else if (clk_en) begin
            if (fire[`RCTR_BIT_INIT]) begin
                // Restart from the present reading, even while stopped
                dyn_max <= shown;
                dyn_min <= shown;
            end else if (!stopped) begin
                if (lt_s(dyn_max, shown))
                    dyn_max <= shown;
                if (lt_s(shown, dyn_min))
                    dyn_min <= shown;
            end
        end
    end

    // One-cycle action strobes
    // They rise about three edges after the pin falls.
    // The print value is held between prints so a slow port can read it.
    always @(posedge clk) begin
        if (!reset_n) begin
            dynamic_memory_init_cmd <= 1'b0;
            print_req               <= 1'b0;
            print_value             <= {`RCTR_VAL_W{1'b0}};
        end else if (clk_en) begin
            dynamic_memory_init_cmd <= fire[`RCTR_BIT_INIT];
            print_req               <= fire[`RCTR_BIT_PRINT];
            if (fire[`RCTR_BIT_PRINT])
                print_value <= display_value;
        end
    end

    // Strict compares: a display equal to a limit is still in tolerance
    assign low_trip  = lt_s(display_value, lower_tol);
    assign high_trip = lt_s(upper_tol, display_value);

    // Low relay, fixed function; de-energised state matches in-tolerance.
    // It lags the display by one edge; no configuration reaches it.
    always @(posedge clk) begin
        if (!reset_n) begin
            low_limit_relay_open_contact    <= 1'b0;
            low_limit_relay_closed_contact  <= 1'b1;
        end else if (clk_en) begin
            low_limit_relay_open_contact    <= low_trip;
            low_limit_relay_closed_contact  <= ~low_trip;
        end
    end

    // High relay, independent of the low one, same contact sense
    always @(posedge clk) begin
        if (!reset_n) begin
            high_limit_relay_open_contact   <= 1'b0;
            high_limit_relay_closed_contact <= 1'b1;
        end else if (clk_en) begin
            high_limit_relay_open_contact   <= high_trip;
            high_limit_relay_closed_contact <= ~high_trip;
        end
    end

endmodule // rctr_top
`default_nettype wire

//--- testbench/rctr_monitor.sv
// Purpose: Assertions on relays, print and freeze
// Assumes: clk_en held high
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "rctr_map.vh"
module rctr_monitor (
    // Clock, reset, pins
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire logic                    print_pin,
    input wire logic                    dynamic_memory_init_pin,
    // Values and flags
    input wire logic [`RCTR_VAL_W-1:0]  display_value,
    input wire logic [`RCTR_VAL_W-1:0]  lower_tol,
    input wire logic [`RCTR_VAL_W-1:0]  upper_tol,
    input wire logic [`RCTR_VAL_W-1:0]  print_value,
    input wire logic                    measure_frozen,
    input wire logic                    print_req,
    input wire logic                    dynamic_memory_init_cmd,
    // Contacts
    input wire logic                    low_limit_relay_open_contact,
    input wire logic                    low_limit_relay_closed_contact,
    input wire logic                    high_limit_relay_open_contact,
    input wire logic                    high_limit_relay_closed_contact
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Relays lag the strict signed compares by one edge
    wire lo_trip = $signed(display_value) < $signed(lower_tol);
    wire hi_trip = $signed(display_value) > $signed(upper_tol);
    sequence s_frozen; measure_frozen [*2]; endsequence
    a_low_pair: assert property (low_limit_relay_open_contact ^ low_limit_relay_closed_contact)
        else $error("low contacts equal");
    a_high_pair: assert property (high_limit_relay_open_contact ^ high_limit_relay_closed_contact)
        else $error("high contacts equal");
    a_low_trip: assert property (1 |=> low_limit_relay_open_contact == $past(lo_trip))
        else $error("low relay wrong");
    a_high_trip: assert property (1 |=> high_limit_relay_open_contact == $past(hi_trip))
        else $error("high relay wrong");
    a_print_data: assert property (print_req |-> print_value == $past(display_value))
        else $error("print value wrong");
    a_print_release: assert property (print_pin |=> !print_req)
        else $error("print fired while pressed");
    a_init_release: assert property (dynamic_memory_init_pin |=> !dynamic_memory_init_cmd)
        else $error("init fired while pressed");
    a_freeze_hold: assert property (s_frozen |-> $stable(display_value))
        else $error("display moved while frozen");
endmodule // rctr_monitor
`default_nettype wire

//--- testbench/rctr_plc.sv
// Purpose: Switch contacts driving the five command pins
// Assumes: Pins change on the falling edge
// Notes:   Opto inputs have a pull-down, so an open contact reads low
`timescale 1ns/1ps
`default_nettype none
module rctr_plc (
    // Clock
    input  wire logic       clk,
    // Pins: init, stop, zero, print, preset
    output var  logic [4:0] pins
);
    initial pins = 5'h00;
    // Close contact i for n cycles; short n breaks the hold on purpose
    task automatic hold(input int i, input int n);
        @(negedge clk) pins[i] = 1'b1;
        repeat (n) @(negedge clk);
    endtask
    // Open contact i, which completes the command
    task automatic drop(input int i);
        @(negedge clk) pins[i] = 1'b0;
    endtask
endmodule // rctr_plc
`default_nettype wire

//--- testbench/rctr_top_tb.sv
// Purpose: Self-checking bench for remote commands and relays
// Assumes: Hold shortened to 8 cycles
// Notes:   Display follows raw minus the current origin
`timescale 1ns/1ps
`default_nettype none
module rctr_top_tb;
    localparam int H = 8;
    logic clk = 1'b0, reset_n = 1'b0;
    logic [4:0] pins;
    logic [31:0] raw = 32'h0, mst = 32'h0, lo = 32'h0, hi = 32'h0;
    wire [31:0] disp, dmax, dmin, pval;
    wire frz, icmd, preq, lo_o, lo_c, hi_o, hi_c;
    int n_fail = 0, check_count = 0;
    always #20 clk = ~clk;
    rctr_top #(.HOLD_CYC(H)) dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
        .dynamic_memory_init_pin(pins[0]), .stop_pin(pins[1]), .zero_pin(pins[2]), .print_pin(pins[3]),
        .preset_pin(pins[4]), .raw_measure(raw), .master_value(mst), .lower_tol(lo), .upper_tol(hi),
        .display_value(disp), .dyn_max(dmax), .dyn_min(dmin), .measure_frozen(frz),
        .dynamic_memory_init_cmd(icmd), .print_req(preq), .print_value(pval),
        .low_limit_relay_open_contact(lo_o), .low_limit_relay_closed_contact(lo_c),
        .high_limit_relay_open_contact(hi_o), .high_limit_relay_closed_contact(hi_c));
    rctr_plc plc (.clk(clk), .pins(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("fails=%0d checks=%0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bounded wait for a one-cycle pulse; a miss ends the run
    task automatic wait_pulse(input bit init);
        int k;
        for (k = 0; k < 10 && (init ? icmd : preq) !== 1'b1; k++) @(negedge clk);
        if (k == 10) begin
            n_fail++;
            test_done;
        end
    endtask
    task automatic cmd(input int i);
        plc.hold(i, H + 6);
        plc.drop(i);
    endtask
    task automatic t_zero;
        raw = 32'd100;
        plc.hold(2, H + 6);
        chk(disp, 32'd100);
        plc.drop(2);
        settle(6);
        chk(disp, 32'd0);
        raw = 32'd130;
        settle(4);
        chk(disp, 32'd30);
    endtask
    task automatic t_preset;
        mst = 32'd50;
        cmd(4);
        settle(6);
        chk(disp, 32'd50);
        raw = 32'd140;
        settle(4);
        chk(disp, 32'd60);
    endtask
    task automatic t_print;
        cmd(3);
        wait_pulse(1'b0);
        chk(pval, 32'd60);
        raw = 32'd150;
        plc.hold(3, H - 4);
        plc.drop(3);
        settle(12);
        chk(pval, 32'd60);
    endtask
    task automatic t_stop;
        plc.hold(1, H - 4);
        chk({31'h0, frz}, 32'h0);
        plc.drop(1);
        settle(4);
        plc.hold(1, H + 6);
        chk({31'h0, frz}, 32'h1);
        raw = 32'd170;
        settle(4);
        chk(disp, 32'd70);
        plc.drop(1);
        settle(6);
        chk(disp, 32'd90);
    endtask
    // Part already placed before the init command
    task automatic t_init;
        cmd(0);
        wait_pulse(1'b1);
        settle(2);
        raw = 32'd190;
        settle(4);
        raw = 32'd160;
        settle(4);
        chk(dmax, 32'd110);
        chk(dmin, 32'd80);
    endtask
    // Below, inside and above the band 50..100
    task automatic t_relay;
        lo = 32'd50;
        hi = 32'd100;
        for (int i = 0; i < 3; i++) begin
            raw = 32'd120 + 32'd40 * i;
            settle(4);
            chk({28'h0, lo_o, lo_c, hi_o, hi_c}, (i == 0) ? 32'h9 : (i == 1) ? 32'h5 : 32'h6);
        end
    endtask
    initial begin
        settle(16);
        reset_n = 1'b1;
        t_zero;
        t_preset;
        t_print;
        t_stop;
        t_init;
        t_relay;
        test_done;
    end
endmodule // rctr_top_tb
bind rctr_top rctr_monitor mon (.*);
`default_nettype wire
